// [src/sofc_top.sv]
// serial output frame clock, data clock input and bit mapper settings
`timescale 1ns/1ns
`include "sofc_consts.svh"
module sofc_top (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_spi_sen_n,
    input wire logic i_spi_sclk,
    input wire logic i_spi_sdi,
    output logic o_spi_sdo,
    output logic o_spi_sdo_oe,
    input wire logic i_decimation_bypass,
    input wire logic i_complex_decimation,
    input wire logic i_core_frame_clock,
    input wire logic i_ddc_frame_clock,
    output logic [7:0] o_interface_mode,
    output logic o_ext_data_clock_buffer_enable,
    output logic o_data_clock_output_enable,
    output sofc_pkg::sofc_frame_cfg_s o_frame_cfg,
    output logic o_frame_clock,
    output logic o_frame_clock_oe,
    output logic o_mapper_active,
    output logic [4:0] o_out_width
);
    import sofc_pkg::*;

    logic wr_valid;
    sofc_wr_s wr;
    logic [14:0] rd_addr;
    logic [7:0] rd_data;
    logic [7:0] mode_reg;
    logic [7:0] fuse_reg;
    logic [7:0] data_clock_input_control;
    logic [7:0] frame_clock_control;
    logic [7:0] output_resolution_mapper;
    logic [7:0] output_control;
    logic sel_prev;
    logic half_rate;
    logic [4:0] next_width;

    sofc_spi_slave u_spi (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_spi_sen_n(i_spi_sen_n),
        .i_spi_sclk(i_spi_sclk),
        .i_spi_sdi(i_spi_sdi),
        .o_spi_sdo(o_spi_sdo),
        .o_spi_sdo_oe(o_spi_sdo_oe),
        .o_wr_valid(wr_valid),
        .o_wr(wr),
        .o_rd_addr(rd_addr),
        .i_rd_data(rd_data)
    );

    wire wr_mode = wr_valid && wr.addr == `SOFC_OFS_MODE;
    wire wr_fuse = wr_valid && wr.addr == `SOFC_OFS_FUSE;
    wire wr_dclk = wr_valid && wr.addr == `SOFC_OFS_DCLK_IN;
    wire wr_frame = wr_valid && wr.addr == `SOFC_OFS_FRAME;
    wire wr_mapper = wr_valid && wr.addr == `SOFC_OFS_MAPPER;
    wire wr_out = wr_valid && wr.addr == `SOFC_OFS_OUT_CTRL;

    // load takes effect when the bit is written back low after a high
    wire fuse_load = wr_fuse && fuse_reg[`SOFC_BIT_FUSE_LD]
        && !wr.data[`SOFC_BIT_FUSE_LD];

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mode_reg <= `SOFC_RST_MODE;
            fuse_reg <= `SOFC_RST_FUSE;
        end else begin
            if (wr_mode) begin
                mode_reg <= wr.data;
            end
            if (wr_fuse) begin
                fuse_reg <= wr.data;
            end
        end
    end

    // the fuse load returns the data clock, frame clock, mapper and output settings to their reset values; the mode keeps its value
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            data_clock_input_control <= `SOFC_RST_DCLK_IN;
            frame_clock_control <= `SOFC_RST_FRAME;
            output_resolution_mapper <= `SOFC_RST_MAPPER;
            output_control <= `SOFC_RST_OUT_CTRL;
        end else if (fuse_load) begin
            data_clock_input_control <= `SOFC_RST_DCLK_IN;
            frame_clock_control <= `SOFC_RST_FRAME;
            output_resolution_mapper <= `SOFC_RST_MAPPER;
            output_control <= `SOFC_RST_OUT_CTRL;
        end else begin
            if (wr_dclk) begin
                data_clock_input_control <= wr.data;
            end
            if (wr_frame) begin
                frame_clock_control <= wr.data;
            end
            if (wr_mapper) begin
                output_resolution_mapper <= wr.data;
            end
            if (wr_out) begin
                output_control <= wr.data;
            end
        end
    end

    // readback; unmapped addresses read zero
    assign rd_data =
        (rd_addr == `SOFC_OFS_MODE) ? mode_reg :
        (rd_addr == `SOFC_OFS_FUSE) ? fuse_reg :
        (rd_addr == `SOFC_OFS_DCLK_IN) ? data_clock_input_control :
        (rd_addr == `SOFC_OFS_FRAME) ? frame_clock_control :
        (rd_addr == `SOFC_OFS_MAPPER) ? output_resolution_mapper :
        (rd_addr == `SOFC_OFS_OUT_CTRL) ? output_control : 8'h00;

    wire frame_src = frame_clock_control[`SOFC_BIT_FRAME_SRC];
    wire frame_div = frame_clock_control[`SOFC_BIT_FRAME_DIV];
    wire frame_en = frame_clock_control[`SOFC_BIT_FRAME_EN];
    wire frame_stretch = frame_clock_control[`SOFC_BIT_FRAME_STRETCH];
    wire mapper_en = output_resolution_mapper[`SOFC_BIT_MAPPER_EN];
    wire wide_en = output_resolution_mapper[`SOFC_BIT_WIDE_EN];
    wire [2:0] res_code =
        output_resolution_mapper[`SOFC_RES_HI:`SOFC_RES_LO];

    // both enable bits must be set to power the input buffer
    wire dclk_in_en = data_clock_input_control[`SOFC_BIT_DCLK_IN_EN]
        & output_control[`SOFC_BIT_OUT_DCLK_IN_EN];

    // frame clock origin: core when clear, downconverter when set
    wire frame_sel = frame_src ? i_ddc_frame_clock
        : i_core_frame_clock;
    wire frame_rise = frame_sel & ~sel_prev;
    wire frame_slow = frame_div | frame_stretch;
    wire mapper_on = mapper_en & i_decimation_bypass;

    // half rate toggle spans the A and B words when stretching
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sel_prev <= 1'b0;
            half_rate <= 1'b0;
        end else begin
            sel_prev <= frame_sel;
            if (frame_rise) begin
                half_rate <= ~half_rate;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_frame_clock <= 1'b0;
            o_frame_clock_oe <= 1'b0;
        end else begin
            o_frame_clock <= frame_en
                & (frame_slow ? half_rate : frame_sel);
            o_frame_clock_oe <= frame_en;
        end
    end

    // width chosen through the mapper, or the mode's native width
    always_comb begin
        next_width = i_complex_decimation ? `SOFC_WIDTH_16
            : `SOFC_WIDTH_18;
        if (wide_en) begin
            next_width = `SOFC_WIDTH_20;
        end else if (mapper_on) begin
            case (res_code)
                `SOFC_RES_18: next_width = `SOFC_WIDTH_18;
                `SOFC_RES_16: next_width = `SOFC_WIDTH_16;
                `SOFC_RES_14: next_width = `SOFC_WIDTH_14;
                default: next_width = `SOFC_WIDTH_18;
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_out_width <= `SOFC_WIDTH_18;
            o_mapper_active <= 1'b0;
            o_interface_mode <= `SOFC_RST_MODE;
            o_ext_data_clock_buffer_enable <= 1'b0;
            o_data_clock_output_enable <= 1'b0;
            o_frame_cfg <= '0;
        end else begin
            o_out_width <= next_width;
            o_mapper_active <= mapper_on & ~wide_en;
            o_interface_mode <= mode_reg;
            o_ext_data_clock_buffer_enable <= dclk_in_en;
            o_data_clock_output_enable <=
                output_control[`SOFC_BIT_OUT_DCLK_OB_EN];
            o_frame_cfg <= '{source: frame_src, divide: frame_div,
                out_en: frame_en, stretch: frame_stretch};
        end
    end
endmodule : sofc_top

// [src/sofc_consts.svh]
// offsets, field positions, reset values and frame sizes for sofc
`ifndef SOFC_CONSTS_SVH
`define SOFC_CONSTS_SVH

`define SOFC_ADDR_W 15
`define SOFC_FRAME_BITS 24
`define SOFC_ADDR_END 16

`define SOFC_OFS_MODE 15'h0007
`define SOFC_OFS_FUSE 15'h0013
`define SOFC_OFS_DCLK_IN 15'h0018
`define SOFC_OFS_FRAME 15'h0019
`define SOFC_OFS_MAPPER 15'h001B
`define SOFC_OFS_OUT_CTRL 15'h001F

`define SOFC_RST_MODE 8'h00
`define SOFC_RST_FUSE 8'h00
`define SOFC_RST_DCLK_IN 8'h00
`define SOFC_RST_FRAME 8'h02
`define SOFC_RST_MAPPER 8'h00
`define SOFC_RST_OUT_CTRL 8'h10

`define SOFC_BIT_DCLK_IN_EN 4
`define SOFC_BIT_OUT_DCLK_IN_EN 6
`define SOFC_BIT_OUT_DCLK_OB_EN 4
`define SOFC_BIT_FUSE_LD 0
`define SOFC_BIT_FRAME_SRC 7
`define SOFC_BIT_FRAME_DIV 4
`define SOFC_BIT_FRAME_EN 1
`define SOFC_BIT_FRAME_STRETCH 0
`define SOFC_BIT_MAPPER_EN 7
`define SOFC_BIT_WIDE_EN 6
`define SOFC_RES_HI 5
`define SOFC_RES_LO 3

`define SOFC_RES_18 3'h0
`define SOFC_RES_16 3'h1
`define SOFC_RES_14 3'h2
`define SOFC_WIDTH_20 5'h14
`define SOFC_WIDTH_18 5'h12
`define SOFC_WIDTH_16 5'h10
`define SOFC_WIDTH_14 5'h0E

`endif

// [src/sofc_pkg.sv]
// types shared by the sofc register bank and its serial port
package sofc_pkg;
    typedef struct packed {
        logic [14:0] addr;
        logic [7:0] data;
    } sofc_wr_s;

    typedef struct packed {
        logic source;
        logic divide;
        logic out_en;
        logic stretch;
    } sofc_frame_cfg_s;

    typedef enum logic [1:0] {
        SOFC_IDLE = 2'h0,
        SOFC_ADDR = 2'h1,
        SOFC_DATA = 2'h2
    } sofc_spi_e;
endpackage : sofc_pkg

// [src/sofc_spi_slave.sv]
// serial register port: sampled enable, clock and data, 24-bit frames
`timescale 1ns/1ns
`include "sofc_consts.svh"
module sofc_spi_slave (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_spi_sen_n,
    input wire logic i_spi_sclk,
    input wire logic i_spi_sdi,
    output logic o_spi_sdo,
    output logic o_spi_sdo_oe,
    output logic o_wr_valid,
    output sofc_pkg::sofc_wr_s o_wr,
    output logic [14:0] o_rd_addr,
    input wire logic [7:0] i_rd_data
);
    import sofc_pkg::*;

    logic [1:0] sen_sync;
    logic [2:0] sclk_sync;
    logic [1:0] sdi_sync;
    logic [4:0] bit_cnt;
    logic [22:0] shift_in;
    logic [7:0] shift_out;
    logic read_cmd;
    sofc_spi_e state;
    sofc_spi_e next_state;

    // stage 0 feeds only stage 1; edges are found on stages 1 and 2
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sen_sync <= 2'h3;
            sclk_sync <= 3'h0;
            sdi_sync <= 2'h0;
        end else begin
            sen_sync <= {sen_sync[0], i_spi_sen_n};
            sclk_sync <= {sclk_sync[1:0], i_spi_sclk};
            sdi_sync <= {sdi_sync[0], i_spi_sdi};
        end
    end

    wire sen_act = ~sen_sync[1];
    wire rise = sen_act & sclk_sync[1] & ~sclk_sync[2];
    wire fall = sen_act & ~sclk_sync[1] & sclk_sync[2];
    wire [4:0] next_cnt = bit_cnt + 5'h01;
    wire [23:0] frame = {shift_in, sdi_sync[1]};
    wire addr_done = rise && (next_cnt == 5'(`SOFC_ADDR_END));
    wire frame_done = rise && (next_cnt == 5'(`SOFC_FRAME_BITS));

    always_comb begin
        next_state = state;
        case (state)
            SOFC_IDLE: next_state = sen_act ? SOFC_ADDR : SOFC_IDLE;
            SOFC_ADDR: next_state = addr_done ? SOFC_DATA : SOFC_ADDR;
            SOFC_DATA: next_state = frame_done ? SOFC_IDLE : SOFC_DATA;
            default: next_state = SOFC_IDLE;
        endcase
        if (!sen_act) begin
            next_state = SOFC_IDLE;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state <= SOFC_IDLE;
            bit_cnt <= 5'h00;
            shift_in <= 23'h00_0000;
            read_cmd <= 1'b0;
        end else begin
            state <= next_state;
            if (!sen_act || state == SOFC_IDLE) begin
                bit_cnt <= 5'h00;
            end else if (rise) begin
                bit_cnt <= next_cnt;
                shift_in <= frame[22:0];
                if (addr_done) begin
                    read_cmd <= frame[15];
                end
            end
        end
    end

    assign o_rd_addr = frame[14:0];

    // read data leaves msb first: bit 7 on the last address rising edge, the rest on falling edges
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            shift_out <= 8'h00;
            o_spi_sdo <= 1'b0;
            o_spi_sdo_oe <= 1'b0;
        end else begin
            if (addr_done) begin
                shift_out <= i_rd_data;
                o_spi_sdo <= i_rd_data[7];
            end else if (fall && state == SOFC_DATA && bit_cnt > 5'h10) begin
                shift_out <= {shift_out[6:0], 1'b0};
                o_spi_sdo <= shift_out[6];
            end
            o_spi_sdo_oe <= (state == SOFC_DATA) && read_cmd && sen_act;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_wr_valid <= 1'b0;
            o_wr <= '0;
        end else begin
            o_wr_valid <= frame_done && state == SOFC_DATA && !read_cmd;
            if (frame_done) begin
                o_wr <= '{addr: frame[22:8], data: frame[7:0]};
            end
        end
    end
endmodule : sofc_spi_slave

// [tb/sofc_top_assertions.sv]
// assertions on the config bank ports
`timescale 1ns/1ns
module sofc_top_assertions (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_spi_sen_n,
    input wire logic i_decimation_bypass,
    input wire logic i_complex_decimation,
    input wire logic i_core_frame_clock,
    input wire logic i_ddc_frame_clock,
    input wire logic o_ext_data_clock_buffer_enable,
    input wire sofc_pkg::sofc_frame_cfg_s o_frame_cfg,
    input wire logic o_frame_clock,
    input wire logic o_frame_clock_oe,
    input wire logic o_mapper_active,
    input wire logic [4:0] o_out_width
);
    import sofc_pkg::*;
    // c: source, divide, out_en, stretch
    wire logic [3:0] c = o_frame_cfg;
    wire logic [4:0] w = o_out_width;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);
    property p_buf;
        $changed(o_ext_data_clock_buffer_enable) |-> !i_spi_sen_n;
    endproperty
    a_buf: assert property (p_buf) else $error("buf en moved");
    property p_src;
        c[1] && !c[2] && !c[0] |-> o_frame_clock == (c[3] ?
            $past(i_ddc_frame_clock) : $past(i_core_frame_clock));
    endproperty
    a_src: assert property (p_src) else $error("frame_clock source");
    property p_off;
        !c[1] |-> !o_frame_clock && !o_frame_clock_oe;
    endproperty
    a_off: assert property (p_off) else $error("frame_clock not off");
    property p_str;
        c[0] && $past(c[0]) && c[1] && $past(c[1]) && !c[3]
            && $changed(o_frame_clock) |-> $past(i_core_frame_clock, 2)
            && !$past(i_core_frame_clock, 3);
    endproperty
    a_str: assert property (p_str) else $error("stretch edge");
    property p_byp;
        o_mapper_active |-> $past(i_decimation_bypass) && w != 5'h14;
    endproperty
    a_byp: assert property (p_byp) else $error("mapper mode");
    property p_res;
        o_mapper_active |-> w inside {5'h12, 5'h10, 5'h0E};
    endproperty
    a_res: assert property (p_res) else $error("mapper width");
    property p_def;
        !o_mapper_active && w != 5'h14 |->
            w == ($past(i_complex_decimation) ? 5'h10 : 5'h12);
    endproperty
    a_def: assert property (p_def) else $error("def width");
endmodule : sofc_top_assertions

// [tb/sofc_spi_host.sv]
// serial host model sending 24-bit register frames
`timescale 1ns/1ns
module sofc_spi_host (
    input wire logic i_clk,
    input wire logic i_spi_sdo,
    input wire logic i_spi_sdo_oe,
    output logic o_spi_sen_n,
    output logic o_spi_sclk,
    output logic o_spi_sdi
);
    initial begin
        o_spi_sen_n = 1'b1;
        o_spi_sclk = 1'b0;
        o_spi_sdi = 1'b0;
    end
    // sclk half period is 10 system cycles; sclk idles low
    task automatic xfer(input logic rd, input logic [14:0] a,
            input logic [7:0] d, output logic [7:0] q);
        logic [23:0] f;
        f = {rd, a, d};
        q = 8'h00;
        o_spi_sen_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            o_spi_sdi = f[i];
            repeat (10) @(negedge i_clk);
            if (i < 8) q[i] = i_spi_sdo_oe & i_spi_sdo;
            o_spi_sclk = 1'b1;
            repeat (10) @(negedge i_clk);
            o_spi_sclk = 1'b0;
        end
        repeat (10) @(negedge i_clk);
        o_spi_sen_n = 1'b1;
        // released data line does not keep its last value
        o_spi_sdi = ~o_spi_sdi;
        repeat (4) @(negedge i_clk);
    endtask : xfer
endmodule : sofc_spi_host

// [tb/testbench.sv]
// self-checking bench for the config bank
`timescale 1ns/1ns
`include "sofc_consts.svh"
module testbench;
    import sofc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic byp = 1'b1;
    logic cplx = 1'b0;
    logic cfc = 1'b0;
    logic dfc = 1'b0;
    logic sen_n, sclk, sdi, sdo, oe, buf_en, frame_clock, foe, act, dob;
    logic [7:0] mode;
    logic [4:0] wid;
    sofc_frame_cfg_s cfg;
    int mismatches = 0;
    int cmp_count = 0;
    int ph = 0;
    always #4 clk = ~clk;
    always @(negedge clk) begin
        ph <= ph + 1;
        if (ph % 4 == 3) cfc <= ~cfc;
        if (ph % 6 == 5) dfc <= ~dfc;
    end
    sofc_top i_dut (.i_clk(clk), .i_sys_rst(rst), .i_spi_sen_n(sen_n),
        .i_spi_sclk(sclk), .i_spi_sdi(sdi), .o_spi_sdo(sdo),
        .o_spi_sdo_oe(oe), .i_decimation_bypass(byp),
        .i_complex_decimation(cplx), .i_core_frame_clock(cfc),
        .i_ddc_frame_clock(dfc), .o_interface_mode(mode),
        .o_ext_data_clock_buffer_enable(buf_en),
        .o_data_clock_output_enable(dob), .o_frame_cfg(cfg),
        .o_frame_clock(frame_clock), .o_frame_clock_oe(foe),
        .o_mapper_active(act), .o_out_width(wid));
    sofc_spi_host i_host (.i_clk(clk), .i_spi_sdo(sdo),
        .i_spi_sdo_oe(oe), .o_spi_sen_n(sen_n), .o_spi_sclk(sclk),
        .o_spi_sdi(sdi));
    task automatic chk(string n, logic [7:0] s, logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(logic [14:0] a, logic [7:0] d);
        logic [7:0] q;
        i_host.xfer(1'b0, a, d, q);
    endtask : wr
    task automatic rd(logic [14:0] a, logic [7:0] e);
        logic [7:0] q;
        i_host.xfer(1'b1, a, 8'h00, q);
        chk("read", q, e);
    endtask : rd
    task automatic stop_test;
        $display("cmp %0d err %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test
    task automatic t_reset;
        chk("cfg", {4'h0, cfg}, 8'h02);
        chk("foe", {7'h00, foe}, 8'h01);
        chk("wid", {3'h0, wid}, 8'h12);
        rd(`SOFC_OFS_FRAME, 8'h02);
        rd(`SOFC_OFS_MAPPER, 8'h00);
        rd(15'h0030, 8'h00);
    endtask : t_reset
    task automatic t_dclk;
        wr(`SOFC_OFS_MODE, 8'h01);
        wr(`SOFC_OFS_FUSE, 8'h01);
        wr(`SOFC_OFS_FUSE, 8'h00);
        wr(`SOFC_OFS_DCLK_IN, 8'h10);
        wr(`SOFC_OFS_FRAME, 8'h02);
        chk("buf", {7'h00, buf_en}, 8'h00);
        wr(`SOFC_OFS_OUT_CTRL, 8'h40);
        chk("buf", {7'h00, buf_en}, 8'h01);
        wr(`SOFC_OFS_DCLK_IN, 8'h00);
        chk("buf", {7'h00, buf_en}, 8'h00);
    endtask : t_dclk
    task automatic t_frame;
        for (int s = 0; s < 2; s++) begin
            // downconverter source only with complex decimation
            cplx = s[0];
            byp = ~s[0];
            wr(`SOFC_OFS_FRAME, {s[0], 7'h02});
            chk("cfg", {4'h0, cfg}, {4'h0, s[0], 3'h2});
            repeat (24) @(negedge clk);
        end
        cplx = 1'b0;
        byp = 1'b1;
        wr(`SOFC_OFS_FRAME, 8'h00);
        chk("frame_clock", {6'h00, frame_clock, foe}, 8'h00);
        rd(`SOFC_OFS_FRAME, 8'h00);
    endtask : t_frame
    task automatic t_stretch;
        logic [7:0] v [2] = '{8'h12, 8'h03};
        logic [7:0] e [2] = '{8'h06, 8'h03};
        logic f0;
        int n;
        for (int k = 0; k < 2; k++) begin
            // divide only in 2-wire bypass, stretch only in half-wire complex
            cplx = k[0];
            byp = ~k[0];
            wr(`SOFC_OFS_FRAME, v[k]);
            chk("cfg", {4'h0, cfg}, e[k]);
            f0 = frame_clock;
            n = 0;
            // half-rate frame clock: eight edges in 64 cycles
            repeat (64) begin
                @(negedge clk);
                if (frame_clock !== f0) n++;
                f0 = frame_clock;
            end
            chk("edges", n[7:0], 8'h08);
        end
        cplx = 1'b0;
        byp = 1'b1;
        wr(`SOFC_OFS_FRAME, 8'h02);
    endtask : t_stretch
    task automatic t_mapper;
        logic [7:0] w [3] = '{8'h12, 8'h10, 8'h0E};
        for (int c = 0; c < 3; c++) begin
            wr(`SOFC_OFS_MAPPER, {2'h2, c[2:0], 3'h0});
            chk("wid", {3'h0, wid}, w[c]);
            chk("act", {7'h00, act}, 8'h01);
        end
        wr(`SOFC_OFS_MAPPER, 8'hC8);
        chk("wid", {3'h0, wid}, 8'h14);
        wr(`SOFC_OFS_MAPPER, 8'h88);
        byp = 1'b0;
        repeat (3) @(negedge clk);
        chk("act", {7'h00, act}, 8'h00);
        chk("wid", {3'h0, wid}, 8'h12);
        cplx = 1'b1;
        repeat (3) @(negedge clk);
        chk("wid", {3'h0, wid}, 8'h10);
        cplx = 1'b0;
        byp = 1'b1;
    endtask : t_mapper
    task automatic t_fuse;
        wr(`SOFC_OFS_MODE, 8'h02);
        wr(`SOFC_OFS_FUSE, 8'h01);
        wr(`SOFC_OFS_FUSE, 8'h00);
        rd(`SOFC_OFS_MAPPER, 8'h00);
        chk("mode", mode, 8'h02);
        rd(`SOFC_OFS_OUT_CTRL, 8'h10);
        chk("dob", {7'h00, dob}, 8'h01);
        wr(`SOFC_OFS_DCLK_IN, 8'h10);
        wr(`SOFC_OFS_FRAME, 8'h02);
    endtask : t_fuse
    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        t_reset();
        t_dclk();
        t_frame();
        t_stretch();
        t_mapper();
        t_fuse();
        stop_test();
    end
    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        stop_test();
    end
endmodule : testbench
bind sofc_top sofc_top_assertions i_chk (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .i_spi_sen_n(i_spi_sen_n),
    .i_decimation_bypass(i_decimation_bypass),
    .i_complex_decimation(i_complex_decimation),
    .i_core_frame_clock(i_core_frame_clock),
    .i_ddc_frame_clock(i_ddc_frame_clock),
    .o_ext_data_clock_buffer_enable(o_ext_data_clock_buffer_enable),
    .o_frame_cfg(o_frame_cfg), .o_frame_clock(o_frame_clock),
    .o_frame_clock_oe(o_frame_clock_oe),
    .o_mapper_active(o_mapper_active), .o_out_width(o_out_width));
